// ### hdl/pwm_and_free_running_timer.sv
// 16-bit timer channel: buffered PWM mode and free-running capture/compare.
// Assumes countTick is a one-cycle count clock enable from an outside
// divider and that all pin inputs are synchronous to clk.
// Operation
// - Duty register write arms the PWM reload; a period write alone does not.
// - Armed reload copies both pending values to buffers at counter clear.
// - Duty zero gives constant inactive output; duty irq still every period.
// - Duty equal to period plus one gives constant active output.
// - Duty-match interrupt fires in the cycle the output goes inactive.
// - Mode 101 is free-running; counting starts when count enable is set.
// - Each channel is compare or capture by its own select bit.
// - Enable inverts the output of each compare channel; each compare match irqs and inverts.
// - Count after FFFFH raises overflow irq, sets flag, wraps to zero.
// - Overflow flag stays set until software clears it.
// - Free-running compare writes take effect in the next comparison.
// - Capture edge stores the count and irqs; counter keeps running.
// - PWM period is period value plus one; secondary toggles per period.
// - Overflow flag clear loses to a coincident overflow.
`timescale 1ns/1ps
`default_nettype none
module pwm_and_free_running_timer (
    input wire logic clk,
    input wire logic rst,
    input wire logic countTick,
    input wire logic [2:0] modeField,
    input wire logic countEnableBit,
    input wire logic chan0CaptureSelect,
    input wire logic chan1CaptureSelect,
    input wire pwm_timer_pkg::ccr_write_s ccrWrite,
    input wire logic overflowClear,
    input wire logic captureInputZero,
    input wire logic captureInputOne,
    output logic mainOutputPin,
    output logic secondaryOutputPin,
    output pwm_timer_pkg::irq_s irq,
    output logic overflowFlag,
    output logic [15:0] periodCompareReg,
    output logic [15:0] dutyCompareReg,
    output logic [15:0] counterValue
);
    logic [15:0] cnt_q, cnt_d, buf0_q, buf0_d, buf1_q, buf1_d;
    logic started_q, started_d, armed_q, armed_d, cePrev_q, cePrev_d;
    logic mainPin_q, mainPin_d, secPin_q, secPin_d, ovf_q, ovf_d;
    pwm_timer_pkg::irq_s irq_q, irq_d;
    logic pwmMode, freeMode, running, step, periodMatch, clearEv, transfer;
    logic dutyHit, overflowEv, countStart;
    logic [15:0] cntNext, buf0Next, buf1Next;
    logic [15:0] ccrVal [pwm_timer_pkg::CHANNELS];
    logic capSel [pwm_timer_pkg::CHANNELS];
    logic capIn [pwm_timer_pkg::CHANNELS];
    logic wrEn [pwm_timer_pkg::CHANNELS];
    logic chHit [pwm_timer_pkg::CHANNELS];
    logic chToggle [pwm_timer_pkg::CHANNELS];

    assign capSel[0] = chan0CaptureSelect;
    assign capSel[1] = chan1CaptureSelect;
    assign capIn[0] = captureInputZero;
    assign capIn[1] = captureInputOne;
    assign wrEn[0] = ccrWrite.periodWrite;
    assign wrEn[1] = ccrWrite.dutyWrite;

    genvar g;
    generate
        for (g = 0; g < pwm_timer_pkg::CHANNELS; g++) begin : gChan
            capture_compare_channel uChan (
                .clk(clk),
                .rst(rst),
                .freeRun(freeMode && running),
                .countStep(step),
                .countStart(countStart),
                .captureSelect(capSel[g]),
                .chanCaptureInput(capIn[g]),
                .writeEn(wrEn[g]),
                .writeData(ccrWrite.data),
                .count(cnt_q),
                .countNext(cntNext),
                .captureCompareReg(ccrVal[g]),
                .chanHit(chHit[g]),
                .chanToggle(chToggle[g])
            );
        end
    endgenerate

    always_comb begin
        pwmMode = modeField == pwm_timer_pkg::MODE_PWM;
        freeMode = modeField == pwm_timer_pkg::MODE_FREE;
        running = countEnableBit && (pwmMode || freeMode);
        step = running && countTick;
        countStart = running && !cePrev_q;
        periodMatch = started_q && (cnt_q == buf0_q);
        // From FFFFH the plain increment wraps, giving the start clear too
        cntNext = (pwmMode && periodMatch) ? pwm_timer_pkg::COUNT_ZERO
                                           : cnt_q + pwm_timer_pkg::COUNT_STEP;
        clearEv = step && pwmMode && (cntNext == pwm_timer_pkg::COUNT_ZERO);
        transfer = clearEv && (armed_q || !started_q);
        buf0Next = transfer ? ccrVal[pwm_timer_pkg::CH_PERIOD] : buf0_q;
        buf1Next = transfer ? ccrVal[pwm_timer_pkg::CH_DUTY] : buf1_q;
        dutyHit = step && pwmMode && (cntNext == buf1Next);
        overflowEv = step && freeMode && started_q
                     && (cnt_q == pwm_timer_pkg::COUNT_MAX);
    end

    always_comb begin
        cnt_d = cnt_q;
        started_d = started_q;
        cePrev_d = running;
        if (!running) begin
            cnt_d = pwm_timer_pkg::COUNT_MAX;
            started_d = 1'b0;
        end else if (step) begin
            cnt_d = cntNext;
            started_d = 1'b1;
        end
    end

    always_comb begin
        armed_d = armed_q;
        if (transfer) begin
            armed_d = 1'b0;
        end
        // A duty write racing the transfer keeps the reload armed
        if (ccrWrite.dutyWrite && pwmMode) begin
            armed_d = 1'b1;
        end
        buf0_d = buf0Next;
        buf1_d = buf1Next;
    end

    always_comb begin
        mainPin_d = mainPin_q;
        secPin_d = secPin_q;
        if (pwmMode) begin
            if (!running) begin
                mainPin_d = 1'b0;
            end else if (step) begin
                mainPin_d = cntNext < buf1Next;
            end
            if (clearEv) begin
                secPin_d = !secPin_q;
            end
        end else if (freeMode) begin
            if (chToggle[1]) begin
                mainPin_d = !mainPin_q;
            end
            if (chToggle[0]) begin
                secPin_d = !secPin_q;
            end
        end
    end

    always_comb begin
        irq_d.chan0MatchIrq = pwmMode ? (step && periodMatch)
                                      : chHit[0];
        irq_d.chan1MatchIrq = pwmMode ? dutyHit : chHit[1];
        irq_d.overflowIrq = overflowEv;
        ovf_d = ovf_q;
        if (overflowClear) begin
            ovf_d = 1'b0;
        end
        if (overflowEv) begin
            ovf_d = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q <= pwm_timer_pkg::COUNT_MAX;
            started_q <= 1'b0;
            cePrev_q <= 1'b0;
            armed_q <= 1'b0;
            buf0_q <= pwm_timer_pkg::CCR_RESET;
            buf1_q <= pwm_timer_pkg::CCR_RESET;
            mainPin_q <= 1'b0;
            secPin_q <= 1'b0;
            irq_q <= '0;
            ovf_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            started_q <= started_d;
            cePrev_q <= cePrev_d;
            armed_q <= armed_d;
            buf0_q <= buf0_d;
            buf1_q <= buf1_d;
            mainPin_q <= mainPin_d;
            secPin_q <= secPin_d;
            irq_q <= irq_d;
            ovf_q <= ovf_d;
        end
    end

    assign mainOutputPin = mainPin_q;
    assign secondaryOutputPin = secPin_q;
    assign irq = irq_q;
    assign overflowFlag = ovf_q;
    assign periodCompareReg = ccrVal[pwm_timer_pkg::CH_PERIOD];
    assign dutyCompareReg = ccrVal[pwm_timer_pkg::CH_DUTY];
    assign counterValue = cnt_q;

    property p_reloadNeedsDuty;
        @(posedge clk) disable iff (rst)
        (clearEv && started_q && buf0Next != buf0_q) |-> armed_q;
    endproperty
    a_reloadNeedsDuty: assert property (p_reloadNeedsDuty)
        else $error("buffer reloaded without a duty write");

    property p_bufferCopy;
        @(posedge clk) disable iff (rst)
        (clearEv && armed_q) |=>
        (buf0_q == $past(ccrVal[0]) && buf1_q == $past(ccrVal[1]));
    endproperty
    a_bufferCopy: assert property (p_bufferCopy)
        else $error("pending values not copied at clear");

    property p_zeroDuty;
        @(posedge clk) disable iff (rst)
        (step && pwmMode && buf1Next == pwm_timer_pkg::COUNT_ZERO)
        |=> !mainPin_q && (irq_q.chan1MatchIrq == $past(clearEv));
    endproperty
    a_zeroDuty: assert property (p_zeroDuty)
        else $error("zero duty output not inactive");

    property p_fullDuty;
        @(posedge clk) disable iff (rst)
        (step && pwmMode && buf1Next == buf0Next + pwm_timer_pkg::COUNT_STEP
         && buf0Next != pwm_timer_pkg::COUNT_MAX) |=> mainPin_q;
    endproperty
    a_fullDuty: assert property (p_fullDuty)
        else $error("full duty output not active");

    property p_dutyIrqAtEdge;
        @(posedge clk) disable iff (rst)
        (pwmMode && running && $past(pwmMode && running)
         && $fell(mainPin_q)) |-> irq_q.chan1MatchIrq;
    endproperty
    a_dutyIrqAtEdge: assert property (p_dutyIrqAtEdge)
        else $error("duty irq not aligned with output edge");

    // A start with a tick must leave FFFFH for zero on that same edge
    sequence s_freeStart;
        freeMode && countStart ##0 countTick;
    endsequence
    property p_freeStart;
        @(posedge clk) disable iff (rst)
        s_freeStart |=> cnt_q == pwm_timer_pkg::COUNT_ZERO;
    endproperty
    a_freeStart: assert property (p_freeStart)
        else $error("free-running start not from zero");

    property p_overflow;
        @(posedge clk) disable iff (rst)
        overflowEv |=> irq_q.overflowIrq && ovf_q
        && cnt_q == pwm_timer_pkg::COUNT_ZERO;
    endproperty
    a_overflow: assert property (p_overflow)
        else $error("overflow not flagged and wrapped");

    property p_flagHolds;
        @(posedge clk) disable iff (rst)
        (ovf_q && !overflowClear) || overflowEv |=> ovf_q;
    endproperty
    a_flagHolds: assert property (p_flagHolds)
        else $error("overflow flag lost");

    property p_periodClear;
        @(posedge clk) disable iff (rst)
        (step && pwmMode && periodMatch) |=>
        irq_q.chan0MatchIrq && cnt_q == pwm_timer_pkg::COUNT_ZERO
        && secPin_q != $past(secPin_q);
    endproperty
    a_periodClear: assert property (p_periodClear)
        else $error("period match did not clear and toggle");

    property p_stopHolds;
        @(posedge clk) disable iff (rst)
        !countEnableBit |=> cnt_q == pwm_timer_pkg::COUNT_MAX;
    endproperty
    a_stopHolds: assert property (p_stopHolds)
        else $error("stopped counter not at FFFFH");
endmodule
`default_nettype wire

// ### hdl/pwm_timer_pkg.sv
// Shared constants and carrier types of the PWM and free-running timer.
// Assumes one system clock; the count clock arrives as an enable pulse.
package pwm_timer_pkg;
    localparam int CNT_W = 16;
    localparam int CHANNELS = 2;
    localparam logic [2:0] MODE_PWM = 3'b100;
    localparam logic [2:0] MODE_FREE = 3'b101;
    localparam logic [15:0] COUNT_MAX = 16'hffff;
    localparam logic [15:0] COUNT_ZERO = 16'h0000;
    localparam logic [15:0] COUNT_STEP = 16'h0001;
    localparam logic [15:0] CCR_RESET = 16'h0000;
    localparam int CH_PERIOD = 0;
    localparam int CH_DUTY = 1;

    // One software write to the capture/compare registers
    typedef struct packed {
        logic periodWrite;
        logic dutyWrite;
        logic [15:0] data;
    } ccr_write_s;

    // One-cycle interrupt request pulses
    typedef struct packed {
        logic chan0MatchIrq;
        logic chan1MatchIrq;
        logic overflowIrq;
    } irq_s;
endpackage

// ### hdl/capture_compare_channel.sv
// One capture/compare register with its capture edge and compare match.
// Assumes the capture input is synchronous to clk; a rising level is an edge.
`timescale 1ns/1ps
`default_nettype none
module capture_compare_channel (
    input wire logic clk,
    input wire logic rst,
    input wire logic freeRun,
    input wire logic countStep,
    input wire logic countStart,
    input wire logic captureSelect,
    input wire logic chanCaptureInput,
    input wire logic writeEn,
    input wire logic [15:0] writeData,
    input wire logic [15:0] count,
    input wire logic [15:0] countNext,
    output logic [15:0] captureCompareReg,
    output logic chanHit,
    output logic chanToggle
);
    logic [15:0] ccr_q, ccr_d;
    logic inPrev_q, inPrev_d;
    logic edgeSeen;

    always_comb begin
        edgeSeen = chanCaptureInput && !inPrev_q;
        inPrev_d = chanCaptureInput;
        ccr_d = ccr_q;
        if (writeEn) begin
            ccr_d = writeData;
        end
        // Capture beats a coincident software write: the count is the fact
        if (freeRun && captureSelect && edgeSeen) begin
            ccr_d = count;
        end
        chanHit = 1'b0;
        chanToggle = 1'b0;
        if (freeRun && captureSelect) begin
            chanHit = edgeSeen;
        end else if (freeRun) begin
            chanHit = countStep && (countNext == ccr_q);
            chanToggle = chanHit || countStart;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ccr_q <= pwm_timer_pkg::CCR_RESET;
            inPrev_q <= 1'b0;
        end else begin
            ccr_q <= ccr_d;
            inPrev_q <= inPrev_d;
        end
    end

    assign captureCompareReg = ccr_q;

    sequence s_capEdge;
        freeRun && captureSelect && chanCaptureInput && !inPrev_q;
    endsequence
    property p_captureStores;
        @(posedge clk) disable iff (rst)
        s_capEdge |=> ccr_q == $past(count);
    endproperty
    a_captureStores: assert property (p_captureStores)
        else $error("capture did not store the count");

    property p_freshCompare;
        @(posedge clk) disable iff (rst)
        (writeEn && !(freeRun && captureSelect)) ##1
        (freeRun && !captureSelect && countStep
         && countNext == $past(writeData))
        |-> chanHit;
    endproperty
    a_freshCompare: assert property (p_freshCompare)
        else $error("new compare value not used at once");
endmodule
`default_nettype wire

// ### testbench/capture_pin_model.sv
// Far-side model: the source that drives both capture input pins.
// Assumes the bench calls its tasks just after a rising clock edge, so
// every level change is synchronous to clk as the timer expects.
`timescale 1ns/1ps
`default_nettype none
module capture_pin_model (
    input wire logic clk,
    output logic captureInputZero,
    output logic captureInputOne
);
    // Both lines idle low, so the first raise is a valid rising edge
    initial begin
        captureInputZero = 1'b0;
        captureInputOne = 1'b0;
    end

    task automatic raise(input int ch);
        if (ch == 0) captureInputZero = 1'b1;
        else captureInputOne = 1'b1;
    endtask

    // Holds the line low for n edges so the next raise is a fresh edge
    task automatic drop(input int ch, input int n);
        if (ch == 0) captureInputZero = 1'b0;
        else captureInputOne = 1'b0;
        repeat (n) @(posedge clk);
        #1;
    endtask
endmodule
`default_nettype wire

// ### testbench/tb_top.sv
// Self-checking bench for the PWM and free-running timer.
// Assumes the timer package is compiled first; the count tick is held
// high so the counter steps on every clk and cycle counts equal ticks.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic countTick = 1'b1;
    logic [2:0] modeField = 3'b000;
    logic countEnableBit = 1'b0;
    logic chan0CaptureSelect = 1'b0;
    logic chan1CaptureSelect = 1'b0;
    pwm_timer_pkg::ccr_write_s ccrWrite = '0;
    logic overflowClear = 1'b0;
    wire logic captureInputZero;
    wire logic captureInputOne;
    logic mainOutputPin;
    logic secondaryOutputPin;
    pwm_timer_pkg::irq_s irq;
    logic overflowFlag;
    logic [15:0] periodCompareReg;
    logic [15:0] dutyCompareReg;
    logic [15:0] counterValue;
    int n_mismatch = 0;
    int n_checks = 0;
    logic [15:0] len;
    logic [15:0] hi;
    logic [15:0] d1;
    logic flip;
    logic [1:0] ovfSoft;
    logic sec0;
    logic main0;
    logic [15:0] capA;
    logic [15:0] capB;

    always #25 clk = ~clk;

    pwm_and_free_running_timer dut (
        .clk(clk), .rst(rst), .countTick(countTick), .modeField(modeField),
        .countEnableBit(countEnableBit),
        .chan0CaptureSelect(chan0CaptureSelect),
        .chan1CaptureSelect(chan1CaptureSelect), .ccrWrite(ccrWrite),
        .overflowClear(overflowClear), .captureInputZero(captureInputZero),
        .captureInputOne(captureInputOne), .mainOutputPin(mainOutputPin),
        .secondaryOutputPin(secondaryOutputPin), .irq(irq),
        .overflowFlag(overflowFlag), .periodCompareReg(periodCompareReg),
        .dutyCompareReg(dutyCompareReg), .counterValue(counterValue)
    );

    capture_pin_model partner (
        .clk(clk), .captureInputZero(captureInputZero),
        .captureInputOne(captureInputOne)
    );

    // Inputs always move 1 ns after the edge, away from the sampling edge
    task automatic step(input int n = 1);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic period, input logic [15:0] data);
        ccrWrite.periodWrite = period;
        ccrWrite.dutyWrite = ~period;
        ccrWrite.data = data;
        step();
        ccrWrite = '0;
    endtask

    // Bit 2 is channel 0 match, bit 1 channel 1 match, bit 0 overflow
    task automatic wait_irq(input int b, input int limit);
        int i;
        for (i = 0; i < limit && irq[b] !== 1'b1; i++) step();
        if (i == limit) chk("irq wait", 16'h0001, 16'h0000);
    endtask

    // One PWM period measured between two period-match pulses
    task automatic stats();
        step();
        wait_irq(2, 100);
        sec0 = secondaryOutputPin;
        len = '0;
        hi = '0;
        d1 = '0;
        do begin
            len++;
            hi += mainOutputPin;
            d1 += irq.chan1MatchIrq;
            step();
        end while (irq.chan0MatchIrq !== 1'b1 && len < 100);
        flip = (secondaryOutputPin !== sec0);
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        step(10);
        rst = 1'b0;
        chk("cnt reset", 16'hffff, counterValue);
        chk("pins reset", 16'h0000, {mainOutputPin, secondaryOutputPin});
        modeField = pwm_timer_pkg::MODE_PWM;
        wr(1'b1, 16'h0003);
        wr(1'b0, 16'h0001);
        sec0 = secondaryOutputPin;
        countEnableBit = 1'b1;
        step();
        chk("cnt start", 16'h0000, counterValue);
        chk("main rise", 16'h0001, mainOutputPin);
        chk("sec start", !sec0, secondaryOutputPin);
        step();
        chk("main fall", 16'h0000, mainOutputPin);
        chk("duty irq", 16'h0001, irq.chan1MatchIrq);
        stats();
        chk("period", 16'h0004, len);
        chk("width", 16'h0001, hi);
        chk("duty irqs", 16'h0001, d1);
        chk("sec flip", 16'h0001, flip);
        // Every write lands just after a period match, outside the transfer
        wr(1'b1, 16'h0005);
        stats();
        chk("no reload", 16'h0004, len);
        wr(1'b0, 16'h0001);
        stats();
        chk("reloaded", 16'h0006, len);
        chk("width kept", 16'h0001, hi);
        wr(1'b0, 16'h0000);
        stats();
        chk("zero width", 16'h0000, hi);
        chk("zero irq", 16'h0001, d1);
        wr(1'b0, 16'h0006);
        stats();
        chk("full width", 16'h0006, hi);
        countEnableBit = 1'b0;
        step();
        chk("stop cnt", 16'hffff, counterValue);
        modeField = pwm_timer_pkg::MODE_FREE;
        chan1CaptureSelect = 1'b1;
        wr(1'b1, 16'h0004);
        sec0 = secondaryOutputPin;
        main0 = mainOutputPin;
        countEnableBit = 1'b1;
        step();
        chk("free start", 16'h0000, counterValue);
        chk("cmp pin start", !sec0, secondaryOutputPin);
        chk("cap pin start", main0, mainOutputPin);
        wait_irq(2, 20);
        chk("cmp match", 16'h0004, counterValue);
        chk("cmp pin", sec0, secondaryOutputPin);
        wr(1'b1, 16'h0009);
        wait_irq(2, 20);
        chk("new cmp", 16'h0009, counterValue);
        // Hit on the very next comparison after the write
        wr(1'b1, 16'h000b);
        step();
        chk("fresh cmp", 16'h0001, irq.chan0MatchIrq);
        capA = counterValue;
        partner.raise(1);
        step();
        chk("cap irq", 16'h0001, irq.chan1MatchIrq);
        chk("cap value", capA, dutyCompareReg);
        chk("no clear", capA + 16'h0001, counterValue);
        capA = dutyCompareReg;
        partner.drop(1, 5);
        capB = counterValue;
        partner.raise(1);
        partner.raise(0);
        step();
        chk("pulse width", 16'h0006, dutyCompareReg - capA);
        chk("cap again", capB, dutyCompareReg);
        chk("cmp untouched", 16'h000b, periodCompareReg);
        for (int i = 0; i < 70000 && counterValue !== 16'hffff; i++) step();
        // Clear raised on the very edge that overflows
        overflowClear = 1'b1;
        step();
        overflowClear = 1'b0;
        chk("ovf irq", 16'h0001, irq.overflowIrq);
        chk("wrap", 16'h0000, counterValue);
        chk("flag wins", 16'h0001, overflowFlag);
        step(3);
        chk("flag sticky", 16'h0001, overflowFlag);
        // The bench keeps two software copies of the flag before the shared clear
        ovfSoft = {overflowFlag, overflowFlag};
        overflowClear = 1'b1;
        step();
        overflowClear = 1'b0;
        ovfSoft[0] = 1'b0;
        step();
        chk("flag clear", 16'h0000, overflowFlag);
        chk("ch1 ovf kept", 16'h0002, {ovfSoft[1], overflowFlag});
        end_of_test();
    end

    // About 66k cycles are needed; 100k cycles is the hang limit
    initial begin
        #5000000;
        n_mismatch++;
        end_of_test();
    end
endmodule
`default_nettype wire
